// File: search_engine_defines.vh
// Constants for the header search engine: register indices, fields,
// reset values and SRAM phase codes.
// Assumes a Wishbone byte address of four times the register index.
// Behaviour
// - Direct lookup uses 12 or 8 header bits
// - Table is 4K or 256 words, 4K-aligned
// - Table base is six-bit 4K-block selector
// - Entry holds 18-bit pointer, bit 31 flag
// - Flag plus tunnel enable chooses node type
// - Flag and enable: pointer addresses result node
// - Root plus two bits reads next level
// - Non-terminal nodes repeat until leaf returned
// - Leaf, result base form result pointer
// - Tunnel keeps channel field, optional field replacement
// - Words: tag, header, rx count, tx count
// - Result node two or four words
// - No accounting: two result reads, no writes
// - Accounting: tx read+write, rx three reads+write
// - One table access plus eight or ten
// - Path-only lookups only when tunnelling enabled
// - Engine idle while start bit is zero
// - Up to 4K tree roots per table
// - Extended depth walks ten levels, else eight
// - Two-bit base picks one 64K result block
// - Null pointer drops or forwards by bit
`ifndef SEARCH_ENGINE_DEFINES_VH
`define SEARCH_ENGINE_DEFINES_VH

// Register indices (byte address is index times four)
`define IDX_CFG1 16'h8001
`define IDX_CFG2 16'h8002
`define IDX_TBL 16'h8003
`define IDX_NULL2 16'h800b
`define IDX_NULL1 16'h800c
`define IDX_NULL0 16'h800d
`define IDX_STATUS 16'h8020

// Search configuration one fields
`define B_TUN_EN 0
`define B_START 1
`define B_ACCT 3
`define B_WIDE 5
`define B_EXTEND 6
`define B_FWD 7

// Search configuration two fields
`define B_INSERT 0
`define B_REP_FLOW 1
`define B_REP_PRIO 2

// Reset values
`define RST_CFG1 8'h00
`define RST_CFG2 8'h00
`define RST_TBL 8'h00
`define RST_NULL 18'h3ffff

// Tree depth limits (last level index)
`define LAST_LVL_SHORT 4'h7
`define LAST_LVL_LONG 4'h9

// Direct entry flag position
`define B_DIRECT_FLAG 31

// SRAM read phases
`define PH_DIR 3'h0
`define PH_TREE 3'h1
`define PH_TAG 3'h2
`define PH_HDR 3'h3
`define PH_RXCNT 3'h4
`define PH_TXCNT 3'h5

`endif

// File: header_search_engine.v
// Receive header search engine: direct table, two-bit tree walk,
// result node fetch and optional per-connection counting.
// Assumes a flow-through SRAM clocked with clk_i and a classic
// Wishbone master for the configuration registers.
`timescale 1ns/1ns
`default_nettype none
`include "search_engine_defines.vh"

module header_search_engine #(
  parameter ADR_W = 32
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [ADR_W-1:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  input wire search_req_i,
  input wire [31:0] header_i,
  input wire tx_count_req_i,
  input wire [17:0] tx_node_ptr_i,
  output reg busy_o,
  output reg result_valid_o,
  output reg cell_pass_o,
  output reg cell_drop_o,
  output reg [31:0] routing_tag_o,
  output reg [31:0] new_header_o,
  output reg [17:0] result_ptr_o,
  output reg [17:0] sram_addr_o,
  output reg [31:0] sram_data_o,
  input wire [31:0] sram_data_i,
  output reg sram_data_oe_o,
  output reg sram_adsp_n_o,
  output reg sram_gw_n_o,
  output reg sram_ce_n_o,
  output reg sram_oe_n_o
);

  // Engine states
  localparam ST_IDLE = 2'd0;
  localparam ST_LAT = 2'd1;
  localparam ST_DATA = 2'd2;

  // Configuration registers
  reg [7:0] cfg1_reg; // Search configuration one
  reg [7:0] cfg2_reg; // Search configuration two
  reg [7:0] tbl_reg; // Table base and result base
  reg [17:0] null_reg; // Null pointer value

  // Engine state
  reg [1:0] state_reg;
  reg [2:0] phase_reg; // Which read is in flight
  reg [3:0] level_reg; // Current tree level
  reg [31:0] hdr_reg; // Header under search
  reg [17:0] res_base_reg; // Result node word one address
  reg tunnel_reg; // Search ended on tunnelling entry
  reg [31:0] tag_reg; // Routing tag word

  // Wishbone decode
  wire wb_req = cyc_i & stb_i & ~ack_o;
  wire [15:0] idx = adr_i[17:2];

  // Config field views
  wire tun_en = cfg1_reg[`B_TUN_EN];
  wire start_en = cfg1_reg[`B_START];
  wire acct_en = cfg1_reg[`B_ACCT];
  wire wide_en = cfg1_reg[`B_WIDE];
  wire ext_en = cfg1_reg[`B_EXTEND];
  wire fwd_en = cfg1_reg[`B_FWD];

  // Last level index of the tree walk
  wire [3:0] last_lvl = ext_en ? `LAST_LVL_LONG : `LAST_LVL_SHORT;

  // Direct table address for a header
  function [17:0] direct_addr;
    input [5:0] base;
    input [31:0] hdr;
    input wide;
    begin
      if (wide)
        direct_addr = {base, hdr[31:20]};
      else
        direct_addr = {base, 4'h0, hdr[27:20]};
    end
  endfunction

  // Tree address from a node and the level's two header bits
  function [17:0] tree_addr;
    input [15:0] node;
    input [31:0] hdr;
    input [3:0] lvl;
    reg [4:0] pos;
    begin
      pos = 5'd19 - {lvl[3:0], 1'b0};
      tree_addr = {node, hdr[pos], hdr[pos-5'd1]};
    end
  endfunction

  // Merge the result header with the original one
  function [31:0] merge_hdr;
    input [31:0] orig;
    input [31:0] newh;
    input tun;
    input [7:0] cfg2;
    reg [31:0] m;
    begin
      m = orig;
      if (tun | cfg2[`B_INSERT])
      begin
        m[27:20] = newh[27:20];
        // Tunnelling keeps the channel field
        if (!tun)
          m[19:4] = newh[19:4];
        if (cfg2[`B_REP_FLOW])
          m[31:28] = newh[31:28];
        if (cfg2[`B_REP_PRIO])
          m[3:0] = newh[3:0];
      end
      merge_hdr = m;
    end
  endfunction

  // Register bus slave: one wait cycle, zero for unmapped reads
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
      cfg1_reg <= `RST_CFG1;
      cfg2_reg <= `RST_CFG2;
      tbl_reg <= `RST_TBL;
      null_reg <= `RST_NULL;
    end
    else
    begin
      ack_o <= wb_req;
      if (wb_req && we_i && sel_i[0])
      begin
        // Writes land in the low byte lane
        if (idx == `IDX_CFG1)
          cfg1_reg <= dat_i[7:0];
        else if (idx == `IDX_CFG2)
          cfg2_reg <= {5'h00, dat_i[2:0]};
        else if (idx == `IDX_TBL)
          tbl_reg <= dat_i[7:0];
        else if (idx == `IDX_NULL2)
          null_reg[17:16] <= dat_i[1:0];
        else if (idx == `IDX_NULL1)
          null_reg[15:8] <= dat_i[7:0];
        else if (idx == `IDX_NULL0)
          null_reg[7:0] <= dat_i[7:0];
      end
      if (wb_req && !we_i)
      begin
        // Read mux
        if (idx == `IDX_CFG1)
          dat_o <= {24'h000000, cfg1_reg};
        else if (idx == `IDX_CFG2)
          dat_o <= {24'h000000, cfg2_reg};
        else if (idx == `IDX_TBL)
          dat_o <= {24'h000000, tbl_reg};
        else if (idx == `IDX_NULL2)
          dat_o <= {30'h0000000, null_reg[17:16]};
        else if (idx == `IDX_NULL1)
          dat_o <= {24'h000000, null_reg[15:8]};
        else if (idx == `IDX_NULL0)
          dat_o <= {24'h000000, null_reg[7:0]};
        else if (idx == `IDX_STATUS)
          dat_o <= {28'h0000000, tunnel_reg, cell_drop_o, cell_pass_o, busy_o};
        else
          dat_o <= 32'h00000000;
      end
    end
  end

  // Search engine and SRAM sequencer
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_IDLE;
      phase_reg <= `PH_DIR;
      level_reg <= 4'h0;
      hdr_reg <= 32'h00000000;
      res_base_reg <= 18'h00000;
      tunnel_reg <= 1'b0;
      tag_reg <= 32'h00000000;
      busy_o <= 1'b0;
      result_valid_o <= 1'b0;
      cell_pass_o <= 1'b0;
      cell_drop_o <= 1'b0;
      routing_tag_o <= 32'h00000000;
      new_header_o <= 32'h00000000;
      result_ptr_o <= 18'h00000;
      sram_addr_o <= 18'h00000;
      sram_data_o <= 32'h00000000;
      sram_data_oe_o <= 1'b0;
      sram_adsp_n_o <= 1'b1;
      sram_gw_n_o <= 1'b1;
      sram_ce_n_o <= 1'b1;
      sram_oe_n_o <= 1'b1;
    end
    else
    begin
      // SRAM strobes last one cycle unless reissued
      result_valid_o <= 1'b0;
      sram_data_oe_o <= 1'b0;
      sram_adsp_n_o <= 1'b1;
      sram_gw_n_o <= 1'b1;
      sram_ce_n_o <= 1'b1;
      sram_oe_n_o <= 1'b1;
      case (state_reg)
        ST_IDLE:
        begin
          // Requests accepted only with the engine started
          if (start_en && search_req_i)
          begin
            busy_o <= 1'b1;
            hdr_reg <= header_i;
            tunnel_reg <= 1'b0;
            phase_reg <= `PH_DIR;
            sram_addr_o <= direct_addr(tbl_reg[5:0], header_i, wide_en);
            sram_ce_n_o <= 1'b0;
            sram_adsp_n_o <= 1'b0;
            sram_oe_n_o <= 1'b0;
            state_reg <= ST_LAT;
          end
          else if (start_en && tx_count_req_i && acct_en)
          begin
            busy_o <= 1'b1;
            phase_reg <= `PH_TXCNT;
            sram_addr_o <= tx_node_ptr_i + 18'h00003;
            sram_ce_n_o <= 1'b0;
            sram_adsp_n_o <= 1'b0;
            sram_oe_n_o <= 1'b0;
            state_reg <= ST_LAT;
          end
        end
        ST_LAT:
        begin
          // Flow-through SRAM: data appears the cycle after
          state_reg <= ST_DATA;
        end
        ST_DATA:
        begin
          // Direct and tree next addresses depend on data just returned
          state_reg <= ST_IDLE;
          case (phase_reg)
            `PH_DIR:
            begin
              if (sram_data_i[17:0] == null_reg)
              begin
                // Unmatched cell
                busy_o <= 1'b0;
                result_valid_o <= 1'b1;
                cell_pass_o <= fwd_en;
                cell_drop_o <= ~fwd_en;
                new_header_o <= hdr_reg;
              end
              else if (sram_data_i[`B_DIRECT_FLAG] && tun_en)
              begin
                // Pointer addresses a result node directly
                tunnel_reg <= 1'b1;
                res_base_reg <= sram_data_i[17:0];
                phase_reg <= `PH_TAG;
                sram_addr_o <= sram_data_i[17:0];
                sram_ce_n_o <= 1'b0;
                sram_adsp_n_o <= 1'b0;
                sram_oe_n_o <= 1'b0;
                state_reg <= ST_LAT;
              end
              else
              begin
                // Root node: start tree walk
                level_reg <= 4'h0;
                phase_reg <= `PH_TREE;
                sram_addr_o <= tree_addr(sram_data_i[15:0], hdr_reg, 4'h0);
                sram_ce_n_o <= 1'b0;
                sram_adsp_n_o <= 1'b0;
                sram_oe_n_o <= 1'b0;
                state_reg <= ST_LAT;
              end
            end
            `PH_TREE:
            begin
              if (sram_data_i[15:0] == null_reg[15:0])
              begin
                // Walk ended on the null pointer
                busy_o <= 1'b0;
                result_valid_o <= 1'b1;
                cell_pass_o <= fwd_en;
                cell_drop_o <= ~fwd_en;
                new_header_o <= hdr_reg;
              end
              else if (level_reg == last_lvl)
              begin
                // Leaf: build result pointer in chosen 64K block
                res_base_reg <= {tbl_reg[7:6], sram_data_i[15:0]};
                phase_reg <= `PH_TAG;
                sram_addr_o <= {tbl_reg[7:6], sram_data_i[15:0]};
                sram_ce_n_o <= 1'b0;
                sram_adsp_n_o <= 1'b0;
                sram_oe_n_o <= 1'b0;
                state_reg <= ST_LAT;
              end
              else
              begin
                // Non-terminal: next level
                level_reg <= level_reg + 4'h1;
                sram_addr_o <= tree_addr(sram_data_i[15:0], hdr_reg, level_reg + 4'h1);
                sram_ce_n_o <= 1'b0;
                sram_adsp_n_o <= 1'b0;
                sram_oe_n_o <= 1'b0;
                state_reg <= ST_LAT;
              end
            end
            `PH_TAG:
            begin
              // Word one is the routing tag
              tag_reg <= sram_data_i;
              phase_reg <= `PH_HDR;
              sram_addr_o <= res_base_reg + 18'h00001;
              sram_ce_n_o <= 1'b0;
              sram_adsp_n_o <= 1'b0;
              sram_oe_n_o <= 1'b0;
              state_reg <= ST_LAT;
            end
            `PH_HDR:
            begin
              // Word two is the new header; parked while counting
              if (acct_en)
              begin
                hdr_reg <= merge_hdr(hdr_reg, sram_data_i, tunnel_reg, cfg2_reg);
                phase_reg <= `PH_RXCNT;
                sram_addr_o <= res_base_reg + 18'h00002;
                sram_ce_n_o <= 1'b0;
                sram_adsp_n_o <= 1'b0;
                sram_oe_n_o <= 1'b0;
                state_reg <= ST_LAT;
              end
              else
              begin
                new_header_o <= merge_hdr(hdr_reg, sram_data_i, tunnel_reg, cfg2_reg);
                routing_tag_o <= tag_reg;
                result_ptr_o <= res_base_reg;
                busy_o <= 1'b0;
                result_valid_o <= 1'b1;
                cell_pass_o <= 1'b1;
                cell_drop_o <= 1'b0;
              end
            end
            `PH_RXCNT:
            begin
              // Receive counter incremented in place, address still set
              new_header_o <= hdr_reg;
              routing_tag_o <= tag_reg;
              result_ptr_o <= res_base_reg;
              sram_data_o <= sram_data_i + 32'h00000001;
              sram_data_oe_o <= 1'b1;
              sram_ce_n_o <= 1'b0;
              sram_adsp_n_o <= 1'b0;
              sram_gw_n_o <= 1'b0;
              busy_o <= 1'b0;
              result_valid_o <= 1'b1;
              cell_pass_o <= 1'b1;
              cell_drop_o <= 1'b0;
            end
            default:
            begin
              // Transmit counter incremented in place
              sram_data_o <= sram_data_i + 32'h00000001;
              sram_data_oe_o <= 1'b1;
              sram_ce_n_o <= 1'b0;
              sram_adsp_n_o <= 1'b0;
              sram_gw_n_o <= 1'b0;
              busy_o <= 1'b0;
            end
          endcase
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // header_search_engine
`default_nettype wire

// File: header_search_monitor.sv
// Port checks for the header search engine.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module header_search_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic search_req_i,
  input wire logic tx_count_req_i,
  input wire logic busy_o,
  input wire logic result_valid_o,
  input wire logic cell_pass_o,
  input wire logic cell_drop_o,
  input wire logic [31:0] routing_tag_o,
  input wire logic [31:0] new_header_o,
  input wire logic sram_data_oe_o,
  input wire logic sram_adsp_n_o,
  input wire logic sram_gw_n_o,
  input wire logic sram_ce_n_o,
  input wire logic sram_oe_n_o
);
  // Single domain, reset disables all checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_bus_ack: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack after request");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_busy_cause: assert property ($rose(busy_o) |-> $past(search_req_i || tx_count_req_i))
    else $error("busy without request");
  a_valid_pulse: assert property (result_valid_o |=> !result_valid_o)
    else $error("valid longer than one cycle");
  a_valid_outcome: assert property (result_valid_o |-> cell_pass_o != cell_drop_o)
    else $error("result without single outcome");
  a_tag_holds: assert property ($changed(routing_tag_o) |-> result_valid_o)
    else $error("tag changed outside result");
  a_header_holds: assert property ($changed(new_header_o) |-> result_valid_o)
    else $error("header changed outside result");
  a_strobe_single: assert property (!sram_ce_n_o |=> sram_ce_n_o)
    else $error("sram access longer than one cycle");
  a_read_strobes: assert property (!sram_ce_n_o && sram_gw_n_o
    |-> !sram_adsp_n_o && !sram_oe_n_o && !sram_data_oe_o)
    else $error("bad read strobes");
  a_write_drive: assert property (!sram_gw_n_o
    |-> !sram_ce_n_o && !sram_adsp_n_o && sram_data_oe_o)
    else $error("bad write strobes");
endmodule // header_search_monitor
bind header_search_engine header_search_monitor u_mon (.*);
`default_nettype wire

// File: sram_model.sv
// Flow-through synchronous SRAM, 256K x 32.
// Assumes it shares the engine clock; idle data toggles.
`timescale 1ns/1ns
`default_nettype none
module sram_model (
  input wire logic clk_i,
  input wire logic [17:0] addr_i,
  input wire logic [31:0] data_i,
  input wire logic data_oe_i,
  input wire logic adsp_n_i,
  input wire logic gw_n_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  output logic [31:0] data_o
);
  logic [31:0] mem [0:262143]; // Filled by the bench
  logic [17:0] addr_reg = 18'h0; // Captured address
  logic rd_reg = 1'b0; // Read data due
  logic [31:0] junk_reg = 32'h5a5a_a5a5; // Idle filler
  int n_rd = 0; // Reads seen
  int n_wr = 0; // Writes seen
  // Capture, count and write
  always @(posedge clk_i)
  begin
    rd_reg <= !ce_n_i && !adsp_n_i && gw_n_i && !oe_n_i;
    junk_reg <= ~junk_reg;
    if (!ce_n_i && !adsp_n_i)
      addr_reg <= addr_i;
    if (!ce_n_i && !adsp_n_i && gw_n_i)
      n_rd <= n_rd + 1;
    if (!ce_n_i && !adsp_n_i && !gw_n_i && data_oe_i)
    begin
      mem[addr_i] <= data_i;
      n_wr <= n_wr + 1;
    end
  end
  // Data flows out in the cycle after capture only
  assign data_o = rd_reg ? mem[addr_reg] : junk_reg;
endmodule // sram_model
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the header search engine.
// Assumes the defines header and a flow-through SRAM model.
`timescale 1ns/1ns
`default_nettype none
`include "search_engine_defines.vh"
module testbench;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [31:0] adr_i = 32'h0, dat_i = 32'h0, header_i = 32'h0, dat_o, routing_tag_o;
  logic [31:0] new_header_o, sram_data_o, sram_data_i, rd;
  logic [3:0] sel_i = 4'h0;
  logic search_req_i = 1'b0, tx_count_req_i = 1'b0, ack_o, busy_o, result_valid_o;
  logic cell_pass_o, cell_drop_o, sram_data_oe_o, sram_adsp_n_o, sram_gw_n_o;
  logic sram_ce_n_o, sram_oe_n_o;
  logic [17:0] tx_node_ptr_i = 18'h0, result_ptr_o, sram_addr_o, p;
  int mismatches = 0, n_checks = 0, i, n0, w0;
  // Row: cfg1, cfg2, header, mode (0 tunnel, 1 tree, 2 null), header, pass, reads, writes
  typedef struct packed {logic [7:0] c1; logic [7:0] c2; logic [31:0] hdr; int mode;
    logic [31:0] eh; logic pass; int rd; int wr;} row_t;
  row_t rows [6] = '{'{8'h03, 8'h00, 32'h0123_4567, 0, 32'h0ab3_4567, 1'b1, 3, 0},
    '{8'h03, 8'h06, 32'h0223_4567, 0, 32'h9ab3_4561, 1'b1, 3, 0},
    '{8'h03, 8'h03, 32'h7335_a5c3, 1, 32'h9abc_def3, 1'b1, 11, 0},
    '{8'h6a, 8'h01, 32'h4447_1e2d, 1, 32'h4abc_defd, 1'b1, 14, 1},
    '{8'h02, 8'h00, 32'h0550_0000, 2, 32'h0550_0000, 1'b0, 1, 0},
    '{8'h82, 8'h00, 32'h0660_0000, 2, 32'h0660_0000, 1'b1, 1, 0}};
  header_search_engine #(.ADR_W(32)) uut (.*);
  sram_model sram (.clk_i(clk_i), .addr_i(sram_addr_o), .data_i(sram_data_o),
    .data_oe_i(sram_data_oe_o), .adsp_n_i(sram_adsp_n_o), .gw_n_i(sram_gw_n_o),
    .ce_n_i(sram_ce_n_o), .oe_n_i(sram_oe_n_o), .data_o(sram_data_i));
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Compare seen against expected
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // Bounded wait: 0 valid, 1 idle, 2 ack
  task automatic wait_on(input int which);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (!((which == 0 && result_valid_o === 1'b1) || (which == 1 && busy_o === 1'b0)
      || (which == 2 && ack_o === 1'b1)) && n < 300);
    if (n >= 300)
    begin
      check(n, 0, "timeout");
      summarize();
    end
  endtask
  // Classic Wishbone single cycle
  task automatic wb(input logic we, input logic [15:0] idx, input logic [7:0] wd);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= we;
    sel_i <= 4'hf;
    adr_i <= {14'h0, idx, 2'b00};
    dat_i <= {24'h0, wd};
    wait_on(2);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // Load direct entry, tree and result node for one row
  task automatic prep(input int r);
    logic [17:0] da;
    logic [15:0] nd;
    int lv, l;
    da = rows[r].c1[5] ? {6'h01, rows[r].hdr[31:20]} : {10'h010, rows[r].hdr[27:20]};
    nd = 16'h2000 + 16'(r * 256);
    lv = rows[r].c1[6] ? 10 : 8;
    p = (rows[r].mode == 0) ? 18'h20000 : {2'b01, nd + 16'h1000};
    sram.mem[da] = (rows[r].mode == 2) ? 32'h0003_ffff :
      (rows[r].mode == 0) ? {14'h2000, p} : {16'h0, nd};
    for (l = 0; l < lv; l++)
      sram.mem[{nd + 16'(l), rows[r].hdr[19 - 2 * l -: 2]}] =
        {16'h0, (l == lv - 1) ? nd + 16'h1000 : nd + 16'(l + 1)};
    sram.mem[p] = 32'hcafe_0001;
    sram.mem[p + 18'h1] = 32'h9abc_def1;
    sram.mem[p + 18'h2] = 32'h5;
    sram.mem[p + 18'h3] = 32'h9;
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `IDX_CFG1, 8'h00);
    check(rd, 32'h0, "cfg1 reset");
    wb(1'b0, `IDX_NULL2, 8'h00);
    check(rd, 32'h3, "null reset");
    wb(1'b1, 16'h0100, 8'hff);
    wb(1'b0, 16'h0100, 8'h00);
    check(rd, 32'h0, "unmapped");
    wb(1'b1, `IDX_TBL, 8'h41);
    wb(1'b0, `IDX_TBL, 8'h00);
    check(rd, 32'h41, "table reg");
    n0 = sram.n_rd;
    search_req_i <= 1'b1;
    @(posedge clk_i);
    search_req_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    check(busy_o, 1'b0, "ran while stopped");
    check(sram.n_rd - n0, 0, "reads while stopped");
    for (i = 0; i < 6; i++)
    begin
      prep(i);
      wb(1'b1, `IDX_CFG2, rows[i].c2);
      wb(1'b1, `IDX_CFG1, rows[i].c1);
      n0 = sram.n_rd;
      w0 = sram.n_wr;
      header_i <= rows[i].hdr;
      search_req_i <= 1'b1;
      @(posedge clk_i);
      search_req_i <= 1'b0;
      wait_on(0);
      check(cell_pass_o, rows[i].pass, "pass");
      check(cell_drop_o, !rows[i].pass, "drop");
      check(new_header_o, rows[i].eh, "header");
      if (rows[i].mode != 2)
      begin
        check(routing_tag_o, 32'hcafe_0001, "tag");
        check(result_ptr_o, p, "result ptr");
      end
      wait_on(1);
      repeat (3) @(posedge clk_i);
      check(sram.n_rd - n0, rows[i].rd, "reads");
      check(sram.n_wr - w0, rows[i].wr, "writes");
    end
    wb(1'b1, `IDX_CFG1, 8'h0a);
    n0 = sram.n_rd;
    w0 = sram.n_wr;
    tx_node_ptr_i <= 18'h13300;
    tx_count_req_i <= 1'b1;
    @(posedge clk_i);
    tx_count_req_i <= 1'b0;
    wait_on(1);
    repeat (3) @(posedge clk_i);
    check(sram.n_rd - n0, 1, "tx reads");
    check(sram.n_wr - w0, 1, "tx writes");
    check(sram.mem[18'h13303], 32'ha, "tx count");
    check(sram.mem[18'h13302], 32'h6, "rx count");
    wb(1'b0, `IDX_STATUS, 8'h00);
    check(rd, 32'h2, "status");
    // Reset again in mid-run: registers and outputs return to idle
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `IDX_CFG1, 8'h00);
    check(rd, 32'h0, "cfg1 after reset");
    check(cell_pass_o, 1'b0, "pass after reset");
    check(busy_o, 1'b0, "busy after reset");
    summarize();
  end
endmodule // testbench
`default_nettype wire
